// ---- src/flash_ctrl_end.sv ----
// Purpose: flash interface sequencer driving the array control lines
// Assumes: array on the same clock; one command at a time
// Notes:   timing held in writable registers, counted in core_clk cycles
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_end #(
	parameter int ADDR_W      = 8,
	parameter int DATA_W      = 16,
	parameter int COL_W       = 3,
	parameter int T_ERASE_CYC = flash_seq_pkg::T_ERASE_CYC,
	parameter int T_ME_CYC    = flash_seq_pkg::T_ME_CYC,
	parameter int T_HV_CYC    = flash_seq_pkg::T_HV_CYC
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Command
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire flash_seq_pkg::op_t   cmd_op,
	input  wire logic                 cmd_info,
	input  wire logic [ADDR_W-1:0]    cmd_addr,
	input  wire logic [DATA_W-1:0]    cmd_wdata,
	// Response
	output logic                      rsp_valid,
	output logic                      rsp_err,
	output logic [DATA_W-1:0]         rsp_rdata,
	// Configuration
	input  wire logic                 smart_mode,
	input  wire logic                 tim_we,
	input  wire logic [2:0]           tim_idx,
	input  wire flash_seq_pkg::tim_t  tim_wdata,
	output flash_seq_pkg::tim_t       tim_rdata,
	// Link
	flash_ctrl_if.ctrl_mp             lnk
);
	localparam int ROW_IW = ADDR_W - COL_W + 1;
	localparam int WORDS  = 2 ** (ADDR_W + 1);
	localparam int ROWS   = 2 ** ROW_IW;
	localparam int TW     = flash_seq_pkg::TIM_W;
	localparam flash_seq_pkg::tim_t TIM_RST [flash_seq_pkg::TIM_N] = '{
		TW'(flash_seq_pkg::T_PROGRAM_STROBE_CYC), TW'(T_ERASE_CYC), TW'(T_ME_CYC),
		TW'(flash_seq_pkg::T_NVS_CYC), TW'(flash_seq_pkg::T_NVH_CYC),
		TW'(flash_seq_pkg::T_NVH1_CYC), TW'(flash_seq_pkg::T_PGS_CYC),
		TW'(flash_seq_pkg::T_RCV_CYC)};
	typedef enum logic [3:0] {
		S_IDLE, S_ADS, S_NVS, S_PGS, S_PULSE, S_PGH, S_NVH, S_RCV, S_READ
	} state_t;
	state_t              state_r;
	state_t              state_nxt;
	flash_seq_pkg::op_t  op_r;
	logic                info_r;
	logic [ADDR_W-1:0]   addr_r;
	logic [DATA_W-1:0]   wdata_r;
	flash_seq_pkg::tim_t cnt_r;
	flash_seq_pkg::tim_t load_val;
	flash_seq_pkg::tim_t tim_r [flash_seq_pkg::TIM_N];
	flash_seq_pkg::tim_t hv_acc_r [ROWS];
	logic [WORDS-1:0]    done_r;
	logic                accept;
	logic                refuse;
	logic                finish;
	logic [ADDR_W:0]     cidx;
	logic [ROW_IW-1:0]   crow;
	logic [TW:0]         hv_sum;
	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic flash_seq_pkg::tim_t less1(input flash_seq_pkg::tim_t v);
		less1 = (v == '0) ? '0 : v - 1'b1;
	endfunction
	function automatic logic erase_row(input logic [ROW_IW-1:0] row,
		input logic whole, input logic info, input logic [ROW_IW-1:0] sel);
		erase_row = whole ? (!row[ROW_IW-1] || info) : (row == sel);
	endfunction
	// ********************************************************
	// Timing registers
	// ********************************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
			for (int i = 0; i < flash_seq_pkg::TIM_N; i++)
				tim_r[i] <= TIM_RST[i];
		else if (ce && tim_we)
			tim_r[tim_idx] <= tim_wdata;
	end
	always_ff @(posedge core_clk)
	begin
		if (rst)
			tim_rdata <= '0;
		else if (ce)
			tim_rdata <= tim_r[tim_idx];
	end
	// ********************************************************
	// Command acceptance
	// ********************************************************
	assign cmd_ready = ce && (state_r == S_IDLE);
	assign accept    = cmd_valid && cmd_ready;
	assign cidx      = {cmd_info, cmd_addr};
	assign crow      = {cmd_info, cmd_addr[ADDR_W-1:COL_W]};
	assign hv_sum    = {1'b0, hv_acc_r[crow]} +
		{1'b0, tim_r[flash_seq_pkg::TI_PROGRAM_STROBE]};
	assign refuse    = (cmd_op == flash_seq_pkg::OP_PROGRAM_STROBE) &&
		(done_r[cidx] || (hv_sum > (TW+1)'(T_HV_CYC)));
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			op_r                      <= flash_seq_pkg::OP_READ;
			{info_r, addr_r, wdata_r} <= '0;
		end
		else if (accept && !refuse)
		begin
			op_r    <= cmd_op;
			info_r  <= cmd_info;
			addr_r  <= cmd_addr;
			wdata_r <= cmd_wdata;
		end
	end
	// ********************************************************
	// Program bookkeeping until the next erase
	// ********************************************************
	// Charged at acceptance, so an aborted pulse still counts as used
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			done_r <= '0;
			for (int r = 0; r < ROWS; r++)
				hv_acc_r[r] <= '0;
		end
		else if (accept && !refuse)
		begin
			if (cmd_op == flash_seq_pkg::OP_PROGRAM_STROBE)
			begin
				done_r[cidx]   <= 1'b1;
				hv_acc_r[crow] <= hv_sum[TW-1:0];
			end
			else if (cmd_op != flash_seq_pkg::OP_READ)
			begin
				for (int w = 0; w < WORDS; w++)
					if (erase_row(w[ADDR_W:COL_W],
						cmd_op == flash_seq_pkg::OP_MERASE, cmd_info, crow))
						done_r[w] <= 1'b0;
				for (int r = 0; r < ROWS; r++)
					if (erase_row(r[ROW_IW-1:0],
						cmd_op == flash_seq_pkg::OP_MERASE, cmd_info, crow))
						hv_acc_r[r] <= '0;
			end
		end
	end
	// ********************************************************
	// Sequencer
	// ********************************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:  if (accept && !refuse)
				state_nxt = (cmd_op == flash_seq_pkg::OP_READ) ? S_READ : S_ADS;
			S_ADS:   state_nxt = S_NVS;
			S_NVS:   if (cnt_r == '0)
				state_nxt = (op_r == flash_seq_pkg::OP_PROGRAM_STROBE) ? S_PGS : S_PULSE;
			S_PGS:   if (cnt_r == '0) state_nxt = S_PULSE;
			S_PULSE: if (cnt_r == '0)
				state_nxt = (op_r == flash_seq_pkg::OP_PROGRAM_STROBE) ? S_PGH : S_NVH;
			S_PGH:   state_nxt = S_NVH;
			S_NVH:   if (cnt_r == '0) state_nxt = S_RCV;
			S_RCV:   if (cnt_r == '0) state_nxt = S_IDLE;
			S_READ:  if (cnt_r == '0) state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end
	// Manual mode applies store set-up and hold; smart mode one cycle
	always_comb
	begin
		load_val = '0;
		case (state_nxt)
			S_NVS:   if (!smart_mode)
				load_val = less1(tim_r[flash_seq_pkg::TI_NVS]);
			S_PGS:   if (!smart_mode)
				load_val = less1(tim_r[flash_seq_pkg::TI_PGS]);
			S_PULSE: case (op_r)
					flash_seq_pkg::OP_PROGRAM_STROBE:
						load_val = less1(tim_r[flash_seq_pkg::TI_PROGRAM_STROBE]);
					flash_seq_pkg::OP_PERASE:
						load_val = less1(tim_r[flash_seq_pkg::TI_ERASE]);
					default:
						load_val = less1(tim_r[flash_seq_pkg::TI_ME]);
				endcase
			S_NVH:   if (!smart_mode)
				load_val = (op_r == flash_seq_pkg::OP_MERASE) ?
					less1(tim_r[flash_seq_pkg::TI_NVH1]) :
					less1(tim_r[flash_seq_pkg::TI_NVH]);
			S_RCV:   load_val = less1(tim_r[flash_seq_pkg::TI_RCV]);
			S_READ:  load_val = TW'(flash_seq_pkg::READ_CYC - 1);
			default: load_val = '0;
		endcase
	end
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_r <= S_IDLE;
			cnt_r   <= '0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				cnt_r <= load_val;
			else if (cnt_r != '0)
				cnt_r <= cnt_r - 1'b1;
		end
	end
	// ********************************************************
	// Control lines
	// ********************************************************
	always_comb
	begin
		lnk.row_addr_enable    = (state_r != S_IDLE);
		lnk.col_addr_enable    = (state_r == S_READ) ||
			(op_r == flash_seq_pkg::OP_PROGRAM_STROBE && state_r == S_PULSE);
		lnk.sense_amp_enable   = (state_r == S_READ);
		lnk.output_enable      = (state_r == S_READ);
		lnk.program_strobe     = (op_r == flash_seq_pkg::OP_PROGRAM_STROBE) &&
			(state_r inside {S_NVS, S_PGS, S_PULSE, S_PGH});
		lnk.erase_strobe       = (op_r inside {flash_seq_pkg::OP_PERASE,
			flash_seq_pkg::OP_MERASE}) && (state_r inside {S_NVS, S_PULSE});
		lnk.store_strobe       = (state_r inside {S_PGS, S_PULSE, S_PGH, S_NVH});
		lnk.whole_block_select = (op_r == flash_seq_pkg::OP_MERASE) &&
			(state_r inside {S_ADS, S_NVS, S_PULSE, S_NVH});
		lnk.info_block_select  = (state_r != S_IDLE) && info_r;
		lnk.addr               = addr_r;
		lnk.wdata              = wdata_r;
	end
	// ********************************************************
	// Response
	// ********************************************************
	assign finish = (state_r inside {S_RCV, S_READ}) && (cnt_r == '0);
	always_ff @(posedge core_clk)
	begin
		if (rst)
			{rsp_valid, rsp_err, rsp_rdata} <= '0;
		else if (ce)
		begin
			rsp_valid <= finish || (accept && refuse);
			rsp_err   <= accept && refuse;
			if (finish && state_r == S_READ)
				rsp_rdata <= lnk.rdata_bus;
		end
	end
endmodule // flash_ctrl_end
`default_nettype wire

// ---- src/flash_seq_pkg.sv ----
// Purpose: shared constants for the flash array link and its sequencer
// Assumes: core_clk at 20 MHz
// Notes:   times are kept in ns; cycle counts derive from them
package flash_seq_pkg;
	localparam int CLK_NS = 50;
	localparam int TIM_W  = 24;
	localparam int TIM_N  = 8;
	// ********************************************************
	// Times in ns
	// ********************************************************
	localparam int T_PROGRAM_STROBE_NS  = 20000;
	localparam int T_ERASE_NS = 20000000;
	localparam int T_ME_NS    = 100000000;
	localparam int T_NVS_NS   = 5000;
	localparam int T_NVH_NS   = 5000;
	localparam int T_NVH1_NS  = 100000;
	localparam int T_PGS_NS   = 10000;
	localparam int T_RCV_NS   = 1000;
	localparam int T_HV_NS    = 3000000;
	// ********************************************************
	// Cycle counts, least times rounded up
	// ********************************************************
	localparam int T_PROGRAM_STROBE_CYC  = (T_PROGRAM_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ME_CYC    = (T_ME_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_NVS_CYC   = (T_NVS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_NVH_CYC   = (T_NVH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_NVH1_CYC  = (T_NVH1_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_PGS_CYC   = (T_PGS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RCV_CYC   = (T_RCV_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_HV_CYC    = (T_HV_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC    = 2;
	// ********************************************************
	// Timing register indices
	// ********************************************************
	localparam logic [2:0] TI_PROGRAM_STROBE  = 3'h0;
	localparam logic [2:0] TI_ERASE = 3'h1;
	localparam logic [2:0] TI_ME    = 3'h2;
	localparam logic [2:0] TI_NVS   = 3'h3;
	localparam logic [2:0] TI_NVH   = 3'h4;
	localparam logic [2:0] TI_NVH1  = 3'h5;
	localparam logic [2:0] TI_PGS   = 3'h6;
	localparam logic [2:0] TI_RCV   = 3'h7;
	typedef logic [TIM_W-1:0] tim_t;
	typedef enum logic [1:0] {OP_READ, OP_PROGRAM_STROBE, OP_PERASE, OP_MERASE} op_t;
endpackage

// ---- src/flash_ctrl_if.sv ----
// Purpose: control lines between sequencer and flash array
// Assumes: one clock, array read bus resolved here
// Notes:   rdata_oe_n low while the array drives the bus
`timescale 1ns/1ps
`default_nettype none
interface flash_ctrl_if #(parameter int ADDR_W = 8, parameter int DATA_W = 16);
	logic              row_addr_enable;
	logic              col_addr_enable;
	logic              sense_amp_enable;
	logic              output_enable;
	logic              program_strobe;
	logic              erase_strobe;
	logic              whole_block_select;
	logic              store_strobe;
	logic              info_block_select;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              rdata_oe_n;
	wire  [DATA_W-1:0] rdata_bus;
	// No tri-state inside the chip: a floated bus reads as zero
	assign rdata_bus = rdata_oe_n ? {DATA_W{1'b0}} : rdata;
	modport array_mp (
		input  row_addr_enable, col_addr_enable, sense_amp_enable,
		input  output_enable, program_strobe, erase_strobe,
		input  whole_block_select, store_strobe, info_block_select,
		input  addr, wdata,
		output rdata, rdata_oe_n
	);
	modport ctrl_mp (
		output row_addr_enable, col_addr_enable, sense_amp_enable,
		output output_enable, program_strobe, erase_strobe,
		output whole_block_select, store_strobe, info_block_select,
		output addr, wdata,
		input  rdata_bus
	);
endinterface
`default_nettype wire

// ---- src/flash_array_end.sv ----
// Purpose: behavioural flash array on the control link
// Assumes: main and info blocks of equal size; page equals row
// Notes:   contents are not cleared by reset, as in real flash
`timescale 1ns/1ps
`default_nettype none
module flash_array_end #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 16,
	parameter int COL_W  = 3
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Link
	flash_ctrl_if.array_mp  lnk
);
	localparam int WORDS = 2 ** (ADDR_W + 1);

	logic [DATA_W-1:0] mem [WORDS];
	logic [DATA_W-1:0] rdata_r;
	logic [ADDR_W:0]   idx;
	logic              row_on;

	// ********************************************************
	// Erase selection
	// ********************************************************
	function automatic logic erase_hit(input logic [ADDR_W:0] w,
		input logic whole, input logic info, input logic [ADDR_W-1:0] a);
		if (whole)
			erase_hit = !w[ADDR_W] || info;
		else
			erase_hit = (w[ADDR_W] == info) &&
				(w[ADDR_W-1:COL_W] == a[ADDR_W-1:COL_W]);
	endfunction

	assign idx    = {lnk.info_block_select, lnk.addr};
	assign row_on = lnk.row_addr_enable;

	// ********************************************************
	// Read path
	// ********************************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata_r <= '0;
		else if (ce && row_on && lnk.col_addr_enable && lnk.sense_amp_enable)
			rdata_r <= mem[idx];
	end

	assign lnk.rdata      = rdata_r;
	assign lnk.rdata_oe_n = !(lnk.output_enable && row_on);

	// ********************************************************
	// Store path
	// ********************************************************
	// Programming only clears bits, so repeated commits are harmless
	always_ff @(posedge core_clk)
	begin
		if (ce && row_on && lnk.store_strobe)
		begin
			if (lnk.program_strobe && lnk.col_addr_enable)
				mem[idx] <= mem[idx] & lnk.wdata;
			else if (lnk.erase_strobe)
			begin
				for (int i = 0; i < WORDS; i++)
					if (erase_hit((ADDR_W+1)'(i), lnk.whole_block_select,
						lnk.info_block_select, lnk.addr))
						mem[i] <= '1;
			end
		end
	end
endmodule // flash_array_end
`default_nettype wire

// ---- dv/flash_link_props.sv ----
// Purpose: concurrent checks on the sequencer to array control lines
// Assumes: one clock; phase lengths match the bench's timing writes
// Notes:   smart mode shortens set-up and hold phases to one cycle
`timescale 1ns/1ps
`default_nettype none
module flash_link_props #(
	parameter int T_NVS  = 4,
	parameter int T_NVH  = 3,
	parameter int T_NVH1 = 6,
	parameter int T_PGS  = 5
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Link lines
	input  wire logic row_addr_enable,
	input  wire logic col_addr_enable,
	input  wire logic sense_amp_enable,
	input  wire logic output_enable,
	input  wire logic program_strobe,
	input  wire logic erase_strobe,
	input  wire logic whole_block_select,
	input  wire logic store_strobe,
	input  wire logic rdata_oe_n
);
	logic       strobe;
	logic [7:0] strb_r;
	logic [7:0] pgs_r;
	logic [7:0] hold_r;
	assign strobe = program_strobe || erase_strobe;
	// ********************************************************
	// Phase counters
	// ********************************************************
	// Eight bits suffice: phases under test stay short
	always_ff @(posedge core_clk)
	begin
		if (rst || !strobe || store_strobe) strb_r <= 8'h00;
		else strb_r <= strb_r + 8'h01;
	end
	always_ff @(posedge core_clk)
	begin
		if (rst || !(store_strobe && program_strobe) || col_addr_enable)
			pgs_r <= 8'h00;
		else pgs_r <= pgs_r + 8'h01;
	end
	always_ff @(posedge core_clk)
	begin
		if (rst || !store_strobe || strobe) hold_r <= 8'h00;
		else hold_r <= hold_r + 8'h01;
	end
	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_read_burst;
		##1 sense_amp_enable ##1 !sense_amp_enable;
	endsequence
	sequence s_recover;
		row_addr_enable [*2] ##1 !row_addr_enable;
	endsequence
	a_read_lines: assert property (
		sense_amp_enable |-> row_addr_enable && col_addr_enable &&
		output_enable && !strobe && !store_strobe)
		else $error("read mode lines wrong");
	a_read_burst: assert property (
		$rose(sense_amp_enable) |-> s_read_burst)
		else $error("read phase length wrong");
	a_program_strobe_lines: assert property (
		col_addr_enable && store_strobe |-> program_strobe &&
		row_addr_enable && !erase_strobe && !sense_amp_enable)
		else $error("program mode lines wrong");
	a_erase_lines: assert property (
		erase_strobe || whole_block_select |-> row_addr_enable &&
		!col_addr_enable && !program_strobe && !sense_amp_enable)
		else $error("erase mode lines wrong");
	a_store_setup: assert property (
		$rose(store_strobe) |-> strb_r == T_NVS || strb_r == 1)
		else $error("store set-up time wrong");
	a_pgs_delay: assert property (
		$rose(col_addr_enable) && program_strobe |->
		pgs_r == T_PGS || pgs_r == 1)
		else $error("program set-up time wrong");
	a_mass_hold: assert property (
		$fell(store_strobe) && $past(whole_block_select) |->
		hold_r == T_NVH1 || hold_r == 1)
		else $error("mass erase store hold wrong");
	a_store_hold: assert property (
		$fell(store_strobe) && !$past(whole_block_select) |->
		hold_r == T_NVH || hold_r == 1)
		else $error("store hold time wrong");
	a_recover_gap: assert property (
		$fell(store_strobe) |-> s_recover)
		else $error("recovery phase wrong");
	a_bus_float: assert property (
		!output_enable && !$past(output_enable) |-> rdata_oe_n)
		else $error("read bus driven while disabled");
	c_mass: cover property ($fell(store_strobe) && $past(whole_block_select));
endmodule // flash_link_props
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: directed bench joining sequencer and array across the link
// Assumes: short erase and timing values keep the run brief
// Notes:   array contents are erased before any read
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                core_clk;
	logic                rst;
	logic                ce;
	logic                cmd_valid;
	logic                cmd_ready;
	flash_seq_pkg::op_t  cmd_op;
	logic                cmd_info;
	logic [7:0]          cmd_addr;
	logic [15:0]         cmd_wdata;
	logic                rsp_valid;
	logic                rsp_err;
	logic [15:0]         rsp_rdata;
	logic                smart_mode;
	logic                tim_we;
	logic [2:0]          tim_idx;
	flash_seq_pkg::tim_t tim_wdata;
	flash_seq_pkg::tim_t tim_rdata;
	flash_seq_pkg::tim_t tv;
	int                  err_count;
	int                  comparisons;
	// Timing values: program_strobe erase mass nvs nvh nvh1 pgs rcv
	localparam logic [23:0] TV [8] = '{24'h00000a, 24'h000014,
		24'h00001e, 24'h000004, 24'h000003, 24'h000006, 24'h000005,
		24'h000002};
	flash_ctrl_if lnk ();
	flash_array_end i_flash_array_end (.core_clk(core_clk), .rst(rst),
		.ce(ce), .lnk(lnk));
	flash_ctrl_end #(.T_ERASE_CYC(50), .T_ME_CYC(80), .T_HV_CYC(200))
		i_flash_ctrl_end (.core_clk(core_clk), .rst(rst), .ce(ce),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_info(cmd_info), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
		.smart_mode(smart_mode), .tim_we(tim_we), .tim_idx(tim_idx),
		.tim_wdata(tim_wdata), .tim_rdata(tim_rdata), .lnk(lnk));
	// Checker defaults equal the phase lengths written from TV
	flash_link_props i_flash_link_props (.core_clk(core_clk), .rst(rst),
		.row_addr_enable(lnk.row_addr_enable),
		.col_addr_enable(lnk.col_addr_enable),
		.sense_amp_enable(lnk.sense_amp_enable),
		.output_enable(lnk.output_enable),
		.program_strobe(lnk.program_strobe),
		.erase_strobe(lnk.erase_strobe),
		.whole_block_select(lnk.whole_block_select),
		.store_strobe(lnk.store_strobe), .rdata_oe_n(lnk.rdata_oe_n));
	// ********************************************************
	// Access tasks
	// ********************************************************
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tim_write(input logic [2:0] idx, input logic [23:0] v);
		@(posedge core_clk);
		tim_we <= 1'b1;
		tim_idx <= idx;
		tim_wdata <= v;
		@(posedge core_clk);
		tim_we <= 1'b0;
	endtask
	task automatic tim_read(input logic [2:0] idx);
		@(posedge core_clk);
		tim_idx <= idx;
		@(posedge core_clk);
		@(negedge core_clk);
		tv = tim_rdata;
	endtask
	// Waits are bounded so a stuck handshake cannot hang the run
	task automatic cmd(input flash_seq_pkg::op_t op, input logic info,
		input logic [7:0] a, input logic [15:0] wd);
		int n;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_info <= info;
		cmd_addr <= a;
		cmd_wdata <= wd;
		n = 0;
		@(negedge core_clk);
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		n = 0;
		@(negedge core_clk);
		while (rsp_valid !== 1'b1 && n < 4000)
		begin
			@(negedge core_clk);
			n++;
		end
		check({23'h0, n < 4000}, 24'h1);
	endtask
	task automatic rd(input logic info, input logic [7:0] a,
		input logic [15:0] exp);
		cmd(flash_seq_pkg::OP_READ, info, a, 16'h0000);
		check({8'h00, rsp_rdata}, {8'h00, exp});
	endtask
	task automatic pg(input logic info, input logic [7:0] a,
		input logic [15:0] wd, input logic exp_err);
		cmd(flash_seq_pkg::OP_PROGRAM_STROBE, info, a, wd);
		check({23'h0, rsp_err}, {23'h0, exp_err});
	endtask
	// ********************************************************
	// Clock, watchdog and tests
	// ********************************************************
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		#(50 * 20000);
		err_count++;
		print_verdict();
	end
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = flash_seq_pkg::OP_READ;
		cmd_info = 1'b0;
		cmd_addr = 8'h00;
		cmd_wdata = 16'h0000;
		smart_mode = 1'b0;
		tim_we = 1'b0;
		tim_idx = 3'h0;
		tim_wdata = 24'h000000;
		err_count = 0;
		comparisons = 0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		check({lnk.row_addr_enable, lnk.col_addr_enable,
			lnk.sense_amp_enable, lnk.output_enable, lnk.program_strobe,
			lnk.erase_strobe, lnk.whole_block_select, lnk.store_strobe},
			24'h0);
		check({23'h0, lnk.rdata_oe_n}, 24'h1);
		tim_read(flash_seq_pkg::TI_PROGRAM_STROBE);
		check(tv, 24'h000190);
		tim_read(flash_seq_pkg::TI_NVH1);
		check(tv, 24'h0007d0);
		for (int i = 0; i < 8; i++)
			tim_write(i[2:0], TV[i]);
		for (int i = 0; i < 8; i++)
		begin
			tim_read(i[2:0]);
			check(tv, TV[i]);
		end
		$display("test timing registers done");
		cmd(flash_seq_pkg::OP_PERASE, 1'b0, 8'h00, 16'h0000);
		check({23'h0, rsp_err}, 24'h0);
		rd(1'b0, 8'h03, 16'hffff);
		pg(1'b0, 8'h03, 16'h1234, 1'b0);
		rd(1'b0, 8'h03, 16'h1234);
		pg(1'b0, 8'h03, 16'h0000, 1'b1);
		rd(1'b0, 8'h03, 16'h1234);
		$display("test main block done");
		cmd(flash_seq_pkg::OP_PERASE, 1'b1, 8'h00, 16'h0000);
		pg(1'b1, 8'h03, 16'habcd, 1'b0);
		rd(1'b1, 8'h03, 16'habcd);
		rd(1'b0, 8'h03, 16'h1234);
		$display("test info block done");
		cmd(flash_seq_pkg::OP_MERASE, 1'b0, 8'h00, 16'h0000);
		rd(1'b0, 8'h03, 16'hffff);
		rd(1'b1, 8'h03, 16'habcd);
		cmd(flash_seq_pkg::OP_MERASE, 1'b1, 8'h00, 16'h0000);
		rd(1'b1, 8'h03, 16'hffff);
		$display("test mass erase done");
		tim_write(flash_seq_pkg::TI_PROGRAM_STROBE, 24'h00003c);
		for (int i = 0; i < 4; i++)
			pg(1'b0, 8'h08 + i[7:0], 16'h0000, i == 3);
		rd(1'b0, 8'h0b, 16'hffff);
		$display("test high voltage budget done");
		@(posedge core_clk);
		smart_mode <= 1'b1;
		tim_write(flash_seq_pkg::TI_PROGRAM_STROBE, 24'h00000a);
		cmd(flash_seq_pkg::OP_PERASE, 1'b0, 8'h08, 16'h0000);
		pg(1'b0, 8'h0b, 16'h5a5a, 1'b0);
		rd(1'b0, 8'h0b, 16'h5a5a);
		repeat (3) @(negedge core_clk);
		check({23'h0, lnk.rdata_oe_n}, 24'h1);
		$display("test smart mode done");
		// Clock enable low must swallow a register write
		@(posedge core_clk);
		ce <= 1'b0;
		tim_write(flash_seq_pkg::TI_RCV, 24'h000009);
		@(negedge core_clk);
		check({23'h0, cmd_ready}, 24'h0);
		@(posedge core_clk);
		ce <= 1'b1;
		tim_read(flash_seq_pkg::TI_RCV);
		check(tv, TV[7]);
		$display("test clock enable done");
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
